// *** core/apt_trigger_ctrl.sv ***
/*
 Trigger selection and request logic for convert pairs 4, 6, 7,
 8 and 9, with its register port and a completion interrupt.
 Assumes trigger inputs are one-cycle pulses synchronous to clk_i,
 and a converter that raises conv_ready_i when free and pulses
 conv_done_i once both channels of the started pair are done.
*/
`timescale 1ns/1ps
`include "apt_regs.svh"

module apt_trigger_ctrl
    import apt_pkg::*;
#(
    parameter int NP = 5,   // Pairs 4, 6, 7, 8, 9
    parameter int AW = 8,   // Register address width
    parameter int DW = 16   // Register data width
) (
    input  wire logic          clk_i,
    input  wire logic          arst_n_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [DW-1:0] wdata_i,
    input  wire logic          wr_i,
    input  wire logic          rd_i,
    output logic      [DW-1:0] rdata_o,
    input  wire logic          glob_soft_trig_i,
    input  wire logic          pwm_special_i,
    input  wire logic          pwm_sec_special_i,
    input  wire logic [7:0]    pwm_pri_trig_i,
    input  wire logic [8:0]    pwm_sec_trig_i,
    input  wire logic [7:0]    pwm_climit_i,
    input  wire logic          tmr1_period_i,
    input  wire logic          tmr2_period_i,
    input  wire logic          conv_ready_i,
    input  wire logic          conv_done_i,
    output logic               conv_start_o,
    output logic      [4:0]    conv_chan_o,
    output logic               irq_o
);

    // Pair tables: register, byte lane, even channel
    localparam logic [AW-1:0] PAIR_OFF [NP] = '{
        `APT_OFF_CTRL2, `APT_OFF_CTRL3, `APT_OFF_CTRL3,
        `APT_OFF_CTRL4, `APT_OFF_CTRL4};
    localparam logic PAIR_HI [NP] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    localparam logic [4:0] PAIR_CH [NP] = '{
        `APT_CH_P4, `APT_CH_P6, `APT_CH_P7,
        `APT_CH_P8, `APT_CH_P9};

    // Register state
    logic          [NP-1:0] ie_q;      // Completion interrupt enables
    logic          [NP-1:0] kick_q;    // Self-clearing software kicks
    logic          [4:0]    sel_q [NP]; // Trigger selects
    logic          [NP-1:0] stat_q;    // Sticky completion status
    logic          [NP-1:0] stat_d;
    logic          [NP-1:0] mask_q;    // Interrupt mask
    logic          [NP-1:0] mask_d;
    apt_state_type          st_q [NP]; // Per-pair request state
    logic          [DW-1:0] rdata_q;
    logic                   start_q;
    logic          [4:0]    chan_q;
    logic                   irq_q;

    // Decoded and selected wires
    logic          [NP-1:0] hit_w;     // Selected trigger fired
    logic          [NP-1:0] pend_w;    // Pending flag readback
    logic          [NP-1:0] wait_w;
    logic          [NP-1:0] busy_w;
    logic          [NP-1:0] done_w;    // Completion per pair
    logic          [NP-1:0] wr_w;      // Write hits pair byte
    logic          [7:0]    wbyte_w [NP];
    logic          [7:0]    rbyte_w [NP];
    logic          [NP-1:0] gnt_w;
    logic          [4:0]    gch_w;
    logic                   free_w;
    logic                   wr_stat_w;
    logic                   wr_mask_w;
    logic          [DW-1:0] rmux_w;

    // Per-pair selection, state and register fields
    for (genvar g = 0; g < NP; g++) begin : g_pair
        logic [31:0] src_w; // Trigger sources indexed by select code

        // Code 0 is tied low so an off pair never fires
        assign src_w = {tmr2_period_i,
                        pwm_climit_i,
                        pwm_sec_trig_i,
                        pwm_sec_special_i,
                        tmr1_period_i,
                        pwm_pri_trig_i,
                        pwm_special_i,
                        glob_soft_trig_i | kick_q[g],
                        kick_q[g],
                        1'b0};
        assign hit_w[g]   = src_w[sel_q[g]];
        assign pend_w[g]  = (st_q[g] != APT_IDLE);
        assign wait_w[g]  = (st_q[g] == APT_WAIT);
        assign busy_w[g]  = (st_q[g] == APT_BUSY);
        assign done_w[g]  = busy_w[g] & conv_done_i;
        assign wr_w[g]    = wr_i & (addr_i == PAIR_OFF[g]);
        // Byte lane picked by the pair's position
        assign wbyte_w[g] = PAIR_HI[g]
                          ? wdata_i[`APT_HI_MSB:`APT_HI_LSB]
                          : wdata_i[`APT_LO_MSB:`APT_LO_LSB];
        assign rbyte_w[g] = {ie_q[g], pend_w[g], kick_q[g], sel_q[g]};

        // Request state; a second trigger while pending is dropped
        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                st_q[g] <= APT_IDLE;
            end else begin
                case (st_q[g])
                    APT_IDLE: begin
                        if (hit_w[g]) begin
                            st_q[g] <= APT_WAIT;
                        end
                    end
                    APT_WAIT: begin
                        // Held until the converter is free
                        if (gnt_w[g] && free_w) begin
                            st_q[g] <= APT_BUSY;
                        end
                    end
                    APT_BUSY: begin
                        if (conv_done_i) begin
                            st_q[g] <= APT_IDLE;
                        end
                    end
                    default: begin
                        st_q[g] <= APT_IDLE;
                    end
                endcase
            end
        end

        // Control fields; a write of one to the kick wins over clear
        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                ie_q[g]   <= 1'b0;
                kick_q[g] <= 1'b0;
                sel_q[g]  <= `APT_SEL_RST;
            end else if (wr_w[g]) begin
                ie_q[g]   <= wbyte_w[g][`APT_IE_BIT];
                kick_q[g] <= wbyte_w[g][`APT_KICK_BIT];
                sel_q[g]  <= wbyte_w[g][`APT_SEL_MSB:`APT_SEL_LSB];
            end else if (hit_w[g] && !pend_w[g]) begin
                kick_q[g] <= 1'b0;
            end
        end
    end

    // Lowest pair index wins when several wait
    always_comb begin
        gnt_w = '0;
        gch_w = '0;
        for (int i = NP - 1; i >= 0; i--) begin
            if (wait_w[i]) begin
                gnt_w    = '0;
                gnt_w[i] = 1'b1;
                gch_w    = PAIR_CH[i];
            end
        end
    end

    // Converter free only when idle and nothing just started
    assign free_w = conv_ready_i & ~(|busy_w) & ~start_q;

    // Start pulse and channel of the granted pair
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            start_q <= 1'b0;
            chan_q  <= '0;
        end else begin
            start_q <= free_w & (|wait_w);
            if (free_w && (|wait_w)) begin
                chan_q <= gch_w;
            end
        end
    end

    // Status sets only for enabled pairs; set beats clear
    assign wr_stat_w = wr_i & (addr_i == `APT_OFF_STAT);
    assign wr_mask_w = wr_i & (addr_i == `APT_OFF_MASK);
    assign stat_d = (stat_q & ~(wdata_i[NP-1:0] & {NP{wr_stat_w}}))
                  | (done_w & ie_q);
    assign mask_d = wr_mask_w ? wdata_i[NP-1:0] : mask_q;

    // Interrupt registers and level output
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stat_q <= '0;
            mask_q <= '0;
            irq_q  <= 1'b0;
        end else begin
            stat_q <= stat_d;
            mask_q <= mask_d;
            irq_q  <= |(stat_d & mask_d);
        end
    end

    // Read mux; unused upper byte of the first register reads zero
    assign rmux_w =
        (addr_i == `APT_OFF_CTRL2) ? {`APT_BYTE_RST, rbyte_w[0]} :
        (addr_i == `APT_OFF_CTRL3) ? {rbyte_w[2], rbyte_w[1]} :
        (addr_i == `APT_OFF_CTRL4) ? {rbyte_w[4], rbyte_w[3]} :
        (addr_i == `APT_OFF_STAT)  ? {{(DW-NP){1'b0}}, stat_q} :
        (addr_i == `APT_OFF_MASK)  ? {{(DW-NP){1'b0}}, mask_q} :
        '0;

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rd_i ? rmux_w : '0;
        end
    end

    assign rdata_o      = rdata_q;
    assign conv_start_o = start_q;
    assign conv_chan_o  = chan_q;
    assign irq_o        = irq_q;

    // Checks on the pair that each bench scenario drives, and shared
    // logic; a check on an undriven pair would never be exercised
    a_off_no_start: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (st_q[0] == APT_IDLE && sel_q[0] == `APT_SRC_OFF)
        |=> st_q[0] == APT_IDLE)
        else $error("pair started with select off");

    a_soft_kick_req: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (st_q[1] == APT_IDLE && kick_q[1] &&
         (sel_q[1] == `APT_SRC_SOFT || sel_q[1] == `APT_SRC_GLOB))
        |=> st_q[1] == APT_WAIT)
        else $error("software kick did not request");

    a_special_req: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (st_q[0] == APT_IDLE && sel_q[0] == `APT_SRC_SPEC &&
         pwm_special_i) |=> pend_w[0])
        else $error("special event did not request");

    a_primary_req: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (st_q[4] == APT_IDLE && sel_q[4] == `APT_SRC_PRI1 &&
         pwm_pri_trig_i[0]) |=> pend_w[4])
        else $error("primary trigger 1 did not request");

    a_second_req: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (st_q[2] == APT_IDLE && sel_q[2] == `APT_SRC_SEC9 &&
         pwm_sec_trig_i[8]) |=> pend_w[2])
        else $error("secondary trigger 9 did not request");

    a_climit_req: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (st_q[0] == APT_IDLE && sel_q[0] == `APT_SRC_CL8 &&
         pwm_climit_i[7]) |=> pend_w[0])
        else $error("current-limit 8 did not request");

    a_timer_req: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (st_q[1] == APT_IDLE && sel_q[1] == `APT_SRC_TMR2 &&
         tmr2_period_i) |=> pend_w[1])
        else $error("timer 2 match did not request");

    a_kick_clears: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        ($rose(pend_w[1]) && !$past(wr_w[1])) |-> !kick_q[1])
        else $error("kick bit still set with pending");

    a_done_clears: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (busy_w[0] && conv_done_i) |=> !pend_w[0])
        else $error("pending not cleared on completion");

    a_wait_held: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (wait_w[0] && !conv_ready_i) |=> wait_w[0] && !busy_w[0])
        else $error("request lost while converter busy");

    a_done_irq: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (done_w[0] && ie_q[0] && mask_q[0] && !wr_mask_w)
        |=> stat_q[0] ##1 irq_o)
        else $error("enabled completion raised no interrupt");

    a_no_irq_dis: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (done_w[4] && !ie_q[4] && !stat_q[4]) |=> !stat_q[4])
        else $error("disabled completion set status");

    a_start_chan: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (free_w && wait_w[0]) |=> conv_start_o &&
        conv_chan_o == `APT_CH_P4 ##1 busy_w[0])
        else $error("pair 4 started on wrong channel");

    a_wait_no_drop: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        wait_w[0] |=> pend_w[0])
        else $error("waiting request dropped before start");

    a_one_busy: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        $onehot0(busy_w))
        else $error("two pairs converting at once");

    a_start_free: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        conv_start_o |-> $past(conv_ready_i))
        else $error("start issued while converter not ready");

    a_chan_pair9: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (free_w && wait_w[4] && !(|wait_w[3:0]))
        |=> conv_chan_o == `APT_CH_P9)
        else $error("pair 9 started on wrong channel");

    a_off_pair9: assert property (
        @(posedge clk_i) disable iff (!arst_n_i)
        (st_q[4] == APT_IDLE && sel_q[4] == `APT_SRC_OFF)
        |=> st_q[4] == APT_IDLE)
        else $error("pair 9 started with select off");

endmodule

// *** core/apt_regs.svh ***
/*
 Register offsets, field positions, reset values and trigger
 codes of the convert pair trigger control block.
 Assumes a byte-addressed register port, one word per register.
*/
`ifndef APT_REGS_SVH
`define APT_REGS_SVH

// Register byte offsets
`define APT_OFF_CTRL2  8'h00
`define APT_OFF_CTRL3  8'h04
`define APT_OFF_CTRL4  8'h08
`define APT_OFF_STAT   8'h0c
`define APT_OFF_MASK   8'h10

// Field positions inside one pair byte
`define APT_IE_BIT     7
`define APT_PEND_BIT   6
`define APT_KICK_BIT   5
`define APT_SEL_MSB    4
`define APT_SEL_LSB    0

// Byte lanes of a control register
`define APT_LO_MSB     7
`define APT_LO_LSB     0
`define APT_HI_MSB     15
`define APT_HI_LSB     8

// Reset values
`define APT_BYTE_RST   8'h00
`define APT_SEL_RST    5'h00

// Trigger select codes with special handling
`define APT_SRC_OFF    5'h00
`define APT_SRC_SOFT   5'h01
`define APT_SRC_GLOB   5'h02
`define APT_SRC_SPEC   5'h03
`define APT_SRC_PRI1   5'h04
`define APT_SRC_SEC9   5'h16
`define APT_SRC_CL8    5'h1e
`define APT_SRC_TMR2   5'h1f

// Even analog channel of each pair; odd channel is one above
`define APT_CH_P4      5'h08
`define APT_CH_P6      5'h0c
`define APT_CH_P7      5'h0e
`define APT_CH_P8      5'h10
`define APT_CH_P9      5'h12

`endif

// *** core/apt_pkg.sv ***
/*
 Types of the convert pair trigger control block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package apt_pkg;

    // Per-pair request state, one-hot
    typedef enum logic [2:0] {
        APT_IDLE = 3'h1,  // No request outstanding
        APT_WAIT = 3'h2,  // Pending, waiting for the converter
        APT_BUSY = 3'h4   // Both channels being converted
    } apt_state_type;

endpackage

// *** verification/apt_conv_model.sv ***
/*
 Behavioural converter core on the far side of the trigger block.
 Assumes start pulses arrive only while ready is high.
*/
`timescale 1ns/1ps
module apt_conv_model (
    input  wire logic       clk_i,        // System clock
    input  wire logic       arst_n_i,     // Async reset, active low
    input  wire logic       conv_start_i, // Start pulse from block
    input  wire logic [7:0] lat_i,        // Conversion time, cycles
    output logic            conv_ready_o, // Free for a new pair
    output logic            conv_done_o   // Both channels converted
);
    logic [7:0] cnt_q;  // Cycles left of the conversion
    logic       busy_q; // A pair is being converted

    // Low while busy or finishing, so a long lat_i keeps others waiting
    assign conv_ready_o = ~busy_q & ~conv_done_o;

    // Count one conversion down, then pulse done for one cycle
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q       <= 8'h00;
            busy_q      <= 1'b0;
            conv_done_o <= 1'b0;
        end else if (conv_start_i && !busy_q) begin
            cnt_q  <= lat_i;
            busy_q <= 1'b1;
        end else if (busy_q && cnt_q == 8'h00) begin
            busy_q      <= 1'b0;
            conv_done_o <= 1'b1;
        end else begin
            cnt_q       <= cnt_q - 8'h01;
            conv_done_o <= 1'b0;
        end
    end
endmodule

// *** verification/adc_pair_trigger_control_tb.sv ***
/*
 Self-checking bench of the convert pair trigger block.
 Assumes apt_conv_model as converter and one 100 MHz clock.
*/
`timescale 1ns/1ps
`include "apt_regs.svh"
module adc_pair_trigger_control_tb;
    typedef struct packed {
        logic [7:0] off;  // Control register offset
        logic       hi;   // Pair sits in upper byte
        logic [4:0] chan; // Even channel it converts
    } apt_row_type;
    // Pairs 4, 6, 7, 8, 9 in status bit order
    localparam apt_row_type ROWS [5] = '{
        '{`APT_OFF_CTRL2, 1'b0, 5'h08}, '{`APT_OFF_CTRL3, 1'b0, 5'h0c},
        '{`APT_OFF_CTRL3, 1'b1, 5'h0e}, '{`APT_OFF_CTRL4, 1'b0, 5'h10},
        '{`APT_OFF_CTRL4, 1'b1, 5'h12}};

    logic        clk_i             = 1'b0;
    logic        arst_n_i          = 1'b0;
    logic [7:0]  addr_i            = 8'h00;
    logic [15:0] wdata_i           = 16'h0000;
    logic        wr_i              = 1'b0;
    logic        rd_i              = 1'b0;
    logic        glob_soft_trig_i  = 1'b0;
    logic        pwm_special_i     = 1'b0;
    logic        pwm_sec_special_i = 1'b0;
    logic [7:0]  pwm_pri_trig_i    = 8'h00;
    logic [8:0]  pwm_sec_trig_i    = 9'h000;
    logic [7:0]  pwm_climit_i      = 8'h00;
    logic        tmr1_period_i     = 1'b0;
    logic        tmr2_period_i     = 1'b0;
    logic [7:0]  lat               = 8'h06; // Converter speed
    logic [15:0] rdata_o;
    logic        conv_ready_i;
    logic        conv_done_i;
    logic        conv_start_o;
    logic        irq_o;
    logic [4:0]  conv_chan_o;
    logic [4:0]  chq [$];  // Channel of every start, in order
    int          err_total = 0;
    int          n_compared = 0;
    int          n_start = 0;
    int          n_done = 0;

    always #5 clk_i = ~clk_i;

    apt_trigger_ctrl dut_u (.clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i,
        .rd_i, .rdata_o, .glob_soft_trig_i, .pwm_special_i,
        .pwm_sec_special_i, .pwm_pri_trig_i, .pwm_sec_trig_i,
        .pwm_climit_i, .tmr1_period_i, .tmr2_period_i, .conv_ready_i,
        .conv_done_i, .conv_start_o, .conv_chan_o, .irq_o);
    apt_conv_model conv_u (.clk_i, .arst_n_i, .conv_start_i(conv_start_o),
        .lat_i(lat), .conv_ready_o(conv_ready_i),
        .conv_done_o(conv_done_i));

    // Log starts and completions as they cross the converter port
    always @(posedge clk_i) begin
        if (conv_start_o === 1'b1) begin
            n_start++;
            chq.push_back(conv_chan_o);
        end
        if (conv_done_i === 1'b1)
            n_done++;
    end

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [15:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe, so look there
    task automatic rd(logic [7:0] a, logic [15:0] exp, string what);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        check(what, rdata_o, exp);
    endtask

    // Raise or drop the trigger input that a select code names
    task automatic drive(int c, logic v);
        if (c == 2)
            glob_soft_trig_i <= v;
        else if (c == 3)
            pwm_special_i <= v;
        else if (c == 12)
            tmr1_period_i <= v;
        else if (c == 13)
            pwm_sec_special_i <= v;
        else if (c == 31)
            tmr2_period_i <= v;
        else if (c >= 4 && c <= 11)
            pwm_pri_trig_i[c-4] <= v;
        else if (c >= 14 && c <= 22)
            pwm_sec_trig_i[c-14] <= v;
        else if (c >= 23 && c <= 30)
            pwm_climit_i[c-23] <= v;
    endtask

    // One-cycle trigger pulse
    task automatic fire(int c);
        @(posedge clk_i);
        drive(c, 1'b1);
        @(posedge clk_i);
        drive(c, 1'b0);
    endtask

    function automatic logic [15:0] wordp(int p, logic [7:0] b);
        return ROWS[p].hi ? {b, 8'h00} : {8'h00, b};
    endfunction

    // Bounded wait until the converter has finished want conversions
    task automatic settle(int want);
        int i;
        for (i = 0; i < 200; i++) begin
            @(posedge clk_i);
            #1;
            if (n_start == want && n_done == want)
                break;
        end
        // A wait that runs out counts as one mismatch
        check("settle limit", 16'(i / 200), 16'h0000);
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    task automatic irq_is(logic exp);
        @(posedge clk_i);
        #1;
        check("irq", {15'h0000, irq_o}, {15'h0000, exp});
    endtask

    task automatic regs_zero();
        for (int i = 0; i < 5; i++)
            rd(8'(i * 4), 16'h0000, "reset value");
    endtask

    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Watchdog, far beyond the thousand or so cycles the run needs
    initial begin
        #100000;
        err_total++;
        finish_test();
    end

    initial begin
        int          p;
        int          base;
        logic [15:0] w;
        repeat (3) @(posedge clk_i);
        arst_n_i <= 1'b1;
        regs_zero();
        wr(`APT_OFF_MASK, 16'h001f);
        // Every nonzero select code once, pairs in turn, fast and slow converter
        for (int c = 1; c < 32; c++) begin
            p = c % 5;
            base = n_start;
            lat <= (c % 2) ? 8'h01 : 8'h0c;
            w = wordp(p, {3'b100, 5'(c)});
            wr(ROWS[p].off, w);
            fire((c == 31) ? 3 : c + 1);
            rd(ROWS[p].off, w, "foreign source");
            if (c == 1)
                wr(ROWS[p].off, w | wordp(p, 8'h20));
            else
                fire(c);
            rd(ROWS[p].off, w | wordp(p, 8'h40), "pending");
            settle(base + 1);
            check("channel", {11'h000, chq[$]}, {11'h000, ROWS[p].chan});
            rd(ROWS[p].off, w, "pending after done");
            check("irq", {15'h0000, irq_o}, 16'h0001);
            rd(`APT_OFF_STAT, 16'(1 << p), "status");
            wr(`APT_OFF_STAT, 16'h001f);
            irq_is(1'b0);
            wr(ROWS[p].off, 16'h0000);
        end
        // Select zero ignores every source; pending is read-only
        base = n_start;
        wr(`APT_OFF_CTRL2, 16'hff60);
        for (int c = 2; c < 32; c++)
            fire(c);
        settle(base);
        check("start count", 16'(n_start), 16'(base));
        rd(`APT_OFF_CTRL2, 16'h0020, "select zero");
        rd(8'h14, 16'h0000, "unmapped read");
        wr(`APT_OFF_CTRL2, 16'h0000);
        // Busy converter: requests wait, repeats drop, priority order
        lat <= 8'h14;
        base = n_start;
        wr(`APT_OFF_CTRL2, 16'h0083);
        wr(`APT_OFF_CTRL4, 16'h0300);
        wr(`APT_OFF_CTRL3, 16'h0082);
        wr(`APT_OFF_CTRL3, 16'h00a2);
        fire(3);
        fire(3);
        rd(`APT_OFF_CTRL4, 16'h4300, "waiting request");
        rd(`APT_OFF_CTRL2, 16'h00c3, "waiting request");
        settle(base + 3);
        check("start count", 16'(n_start), 16'(base + 3));
        check("first", {11'h000, chq[base]}, 16'h000c);
        check("second", {11'h000, chq[base+1]}, 16'h0008);
        check("third", {11'h000, chq[base+2]}, 16'h0012);
        rd(`APT_OFF_STAT, 16'h0003, "status enables");
        wr(`APT_OFF_MASK, 16'h0000);
        irq_is(1'b0);
        wr(`APT_OFF_MASK, 16'h001f);
        irq_is(1'b1);
        wr(`APT_OFF_STAT, 16'h001f);
        irq_is(1'b0);
        // Reset in mid-run clears everything again
        // Reset lands on the edge that grants pair 6, with pair 7 waiting
        wr(`APT_OFF_CTRL3, 16'h8585);
        fire(5);
        @(posedge clk_i);
        arst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        arst_n_i <= 1'b1;
        regs_zero();
        irq_is(1'b0);
        finish_test();
    end
endmodule
